// File: src/sarro_pkg.sv
// Package of constants and carrier types for the serial converter readout.
package sarro_pkg;
  // ==========================================================
  // Frame geometry
  localparam int unsigned SARRO_RES_BITS = 12;
  localparam logic [4:0] SARRO_FRAME_CYCLE_COUNT = 5'h10;
  localparam logic [4:0] SARRO_SHORT_MIN_CYCLES = 5'h0E;
  // Falling edge that turns the driver on.
  localparam logic [4:0] SARRO_EN_FALL = 5'h02;
  // Falling edge that presents the result MSB.
  localparam logic [4:0] SARRO_MSB_FALL = 5'h03;
  localparam logic [4:0] SARRO_LSB_FALL = 5'h0E;
  localparam logic [4:0] SARRO_FALL_MAX = 5'h1F;
  // ==========================================================
  // Pin timing
  localparam int unsigned SARRO_CLK_PS = 5000;
  localparam int unsigned SARRO_HOLD_NS = 10;
  localparam int unsigned SARRO_OUTPUT_ENABLE_DELAY_NS = 50;
  localparam int unsigned SARRO_OUTPUT_RELEASE_DELAY_NS = 50;
  // Least hold time, rounded up to whole clock cycles.
  localparam logic [3:0] SARRO_HOLD_CYC =
    4'((SARRO_HOLD_NS * 1000 + SARRO_CLK_PS - 1) / SARRO_CLK_PS);
  // ==========================================================
  // Reset values
  localparam logic [11:0] SARRO_SAMPLE_RST = 12'h000;
  localparam logic [4:0] SARRO_FALLS_RST = 5'h00;
  localparam logic [3:0] SARRO_HOLD_RST = 4'h0;
  // Synchronisers start at the pins' idle levels: clock low, select high.
  localparam logic [1:0] SARRO_SCLK_SYNC_RST = 2'h0;
  localparam logic [1:0] SARRO_CS_SYNC_RST = 2'h3;
  // ==========================================================
  // Carrier for one captured sample.
  typedef struct packed {
    logic [11:0] code;
  } sarro_word_t;
endpackage : sarro_pkg

// File: src/sarro_readout.sv
// Serial readout of a 12-bit converter framed by an active-low select.
module sarro_readout
  import sarro_pkg::*;
(
  // System clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Serial link pins; the inputs are asynchronous to the system clock.
  input wire logic i_sclk,
  input wire logic i_cs_n,
  output logic o_dout,
  output logic o_dout_oe,
  // Sample stream from the converter core.
  input wire sarro_word_t i_sample,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  // Frame status.
  output logic o_frame_done
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclk_sync, cs_sync;
  logic sclk_d, cs_d;
  logic [1:0] next_sclk_sync, next_cs_sync;
  logic next_sclk_d, next_cs_d;
  // Three flops per pin; the second and third stages feed edge logic.
  always_comb begin
    next_sclk_sync = {sclk_sync[0], i_sclk};
    next_cs_sync = {cs_sync[0], i_cs_n};
    next_sclk_d = sclk_sync[1];
    next_cs_d = cs_sync[1];
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      // A clock stage reset high would show a false fall after reset.
      sclk_sync <= SARRO_SCLK_SYNC_RST;
      cs_sync <= SARRO_CS_SYNC_RST;
      sclk_d <= 1'h0;
      cs_d <= 1'h1;
    end else begin
      sclk_sync <= next_sclk_sync;
      cs_sync <= next_cs_sync;
      sclk_d <= next_sclk_d;
      cs_d <= next_cs_d;
    end
  end
  logic sclk_fall, cs_fall, cs_high;
  assign sclk_fall = sclk_d & ~sclk_sync[1];
  assign cs_fall = cs_d & ~cs_sync[1];
  assign cs_high = cs_sync[1];
  // ==========================================================
  // Two-entry sample buffer
  // Two slots let the core deliver the next sample while a frame runs.
  sarro_word_t buf_q [2];
  logic [1:0] buf_cnt, next_buf_cnt;
  logic buf_rd, buf_wr;
  sarro_word_t next_buf0, next_buf1;
  // A word is taken only while ready is shown, so both sides agree.
  assign buf_wr = i_sample_valid & o_sample_ready;
  always_comb begin
    next_buf0 = buf_q[0];
    next_buf1 = buf_q[1];
    next_buf_cnt = buf_cnt;
    if (buf_rd && buf_cnt != 2'h0) begin
      // The head stays put when the last word leaves, so an empty
      // buffer repeats the most recent sample rather than a stale one.
      if (buf_cnt == 2'h2) next_buf0 = buf_q[1];
      next_buf_cnt = buf_cnt - 2'h1;
    end
    if (buf_wr) begin
      if (next_buf_cnt == 2'h0) next_buf0 = i_sample;
      else next_buf1 = i_sample;
      next_buf_cnt = next_buf_cnt + 2'h1;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_q[0] <= '{code: SARRO_SAMPLE_RST};
      buf_q[1] <= '{code: SARRO_SAMPLE_RST};
      buf_cnt <= 2'h0;
      o_sample_ready <= 1'h0;
    end else begin
      buf_q[0] <= next_buf0;
      buf_q[1] <= next_buf1;
      buf_cnt <= next_buf_cnt;
      o_sample_ready <= (next_buf_cnt != 2'h2);
    end
  end
  // ==========================================================
  // Frame engine
  typedef enum logic [1:0] {SARRO_IDLE, SARRO_RUN} sarro_state_t;
  sarro_state_t state, next_state;
  logic [4:0] falls, next_falls;
  logic [11:0] shreg, next_shreg;
  logic bit_q, next_bit_q, oe_q, next_oe_q;
  logic [3:0] hold, next_hold;
  logic pend_bit, next_pend_bit, done_q, next_done_q;
  // Bit presented after the given falling edge of the frame.
  function automatic logic frame_bit(input logic [4:0] n,
                                     input logic [11:0] w);
    logic [4:0] i;
    i = 5'h00;
    if (n < SARRO_MSB_FALL) begin
      frame_bit = 1'b0;
    end else if (n <= SARRO_LSB_FALL) begin
      i = SARRO_LSB_FALL - n;
      frame_bit = w[i[3:0]];
    end else if (n <= SARRO_LSB_FALL + 5'h0B) begin
      i = n - SARRO_LSB_FALL;
      frame_bit = w[i[3:0]];
    end else begin
      frame_bit = 1'b0;
    end
  endfunction : frame_bit
  assign buf_rd = (state == SARRO_IDLE) & cs_fall;
  // Select fall latches a sample; each clock fall up to the 31st advances one bit.
  always_comb begin
    next_state = state;
    next_falls = falls;
    next_shreg = shreg;
    next_bit_q = bit_q;
    next_oe_q = oe_q;
    next_hold = hold;
    next_pend_bit = pend_bit;
    next_done_q = 1'b0;
    case (state)
      SARRO_IDLE: begin
        if (cs_fall) begin
          next_state = SARRO_RUN;
          next_falls = SARRO_FALLS_RST;
          next_shreg = buf_q[0].code;
          next_oe_q = 1'b0;
        end
      end
      SARRO_RUN: begin
        if (cs_high) begin
          // Short or full, the frame ends on select rising.
          next_state = SARRO_IDLE;
          next_oe_q = 1'b0;
          next_hold = SARRO_HOLD_RST;
          next_done_q = (falls >= SARRO_SHORT_MIN_CYCLES);
        end else begin
          if (sclk_fall && falls != SARRO_FALL_MAX) begin
            next_falls = falls + 5'h01;
            next_pend_bit = frame_bit(falls + 5'h01, shreg);
            next_hold = SARRO_HOLD_CYC;
            if (falls + 5'h01 == SARRO_EN_FALL) next_oe_q = 1'b1;
          end else if (hold != SARRO_HOLD_RST) begin
            next_hold = hold - 4'h1;
            if (hold == 4'h1) next_bit_q = pend_bit;
          end
        end
      end
      default: next_state = SARRO_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SARRO_IDLE;
      falls <= SARRO_FALLS_RST;
      shreg <= SARRO_SAMPLE_RST;
      bit_q <= 1'b0;
      oe_q <= 1'b0;
      hold <= SARRO_HOLD_RST;
      pend_bit <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state <= next_state;
      falls <= next_falls;
      shreg <= next_shreg;
      bit_q <= next_bit_q;
      oe_q <= next_oe_q;
      hold <= next_hold;
      pend_bit <= next_pend_bit;
      done_q <= next_done_q;
    end
  end
  assign o_dout = bit_q;
  assign o_dout_oe = oe_q;
  assign o_frame_done = done_q;
  // ==========================================================
  // Assertions
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_no_early_drive;
    (state == SARRO_RUN && falls < SARRO_EN_FALL) |-> !o_dout_oe;
  endproperty
  a_no_early_drive: assert property (p_no_early_drive)
    else $error("Data driven before second clock fall.");
  property p_drive_at_second;
    (state == SARRO_RUN && !cs_high && sclk_fall && falls == 5'h01)
      |=> o_dout_oe;
  endproperty
  a_drive_at_second: assert property (p_drive_at_second)
    else $error("Data not driven after second clock fall.");
  property p_release;
    (state == SARRO_RUN && cs_high) |=> !o_dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("Data not released on select rise.");
  property p_only_after_fall;
    $changed(o_dout) |-> $past(hold) == 4'h1;
  endproperty
  a_only_after_fall: assert property (p_only_after_fall)
    else $error("Data changed without a clock fall.");
  sequence s_fall_seen;
    state == SARRO_RUN && !cs_high && sclk_fall && falls < 5'h1E;
  endsequence
  property p_hold_then_change;
    s_fall_seen ##1 (!sclk_fall && !cs_high) [*2] |=> o_dout == pend_bit;
  endproperty
  a_hold_then_change: assert property (p_hold_then_change)
    else $error("Next bit not presented after hold.");
  property p_null_first;
    (state == SARRO_RUN && falls == SARRO_EN_FALL && hold == 4'h0)
      |-> o_dout == 1'b0;
  endproperty
  a_null_first: assert property (p_null_first)
    else $error("Leading null bit missing.");
  property p_done_len;
    o_frame_done |-> $past(falls) >= SARRO_SHORT_MIN_CYCLES;
  endproperty
  a_done_len: assert property (p_done_len)
    else $error("Frame reported done too early.");
  property p_frame_start;
    (state == SARRO_IDLE && cs_fall) |=> state == SARRO_RUN && falls == 5'h00;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("Frame did not start on select fall.");
endmodule : sarro_readout

// File: testbench/sarro_host_model.sv
// Host side model that frames conversions and captures the serial result.
module sarro_host_model (
  // Clock that paces the host.
  input wire logic i_sys_clk,
  // Serial pins.
  input wire logic i_dout,
  input wire logic i_dout_oe,
  output logic o_sclk,
  output logic o_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period is wide enough for the device's input synchronisers.
  localparam int HALF = 8;

  // The clock stands low and select high outside frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge i_sys_clk);
  endtask : wait_half

  // ==========================================================
  // One frame of n falling edges; a released pin reads as zero.
  task automatic frame(input int n, output logic [31:0] bits,
                       output logic [31:0] oes);
    bits = '0;
    oes = '0;
    o_cs_n <= 1'b0;
    wait_half();
    for (int k = 1; k <= n + 1; k++) begin
      o_sclk <= 1'b1;
      wait_half();
      if (k > 1) begin
        bits[k-1] = i_dout_oe & i_dout;
        oes[k-1] = i_dout_oe;
      end
      if (k <= n) begin
        o_sclk <= 1'b0;
      end else begin
        o_cs_n <= 1'b1;
      end
      wait_half();
    end
    o_sclk <= 1'b0;
  endtask : frame
endmodule : sarro_host_model

// File: testbench/tb_top.sv
// Self-checking bench for the serial converter readout.
module tb_top
  import sarro_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, sclk, cs_n, dout, oe, valid, ready, done;
  sarro_word_t sample;
  int err_count, samples_checked, done_seen, done_exp, cycles;
  int nf [6] = '{16, 14, 25, 10, 15, 16};
  logic [11:0] q [$];
  logic [11:0] last, code;
  logic [31:0] bits, oes, exp_b, exp_o;

  sarro_readout uut (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .o_dout(dout), .o_dout_oe(oe), .i_sample(sample),
    .i_sample_valid(valid), .o_sample_ready(ready), .o_frame_done(done));
  sarro_host_model host (.i_sys_clk(clk), .i_dout(dout),
    .i_dout_oe(oe), .o_sclk(sclk), .o_cs_n(cs_n));

  always #2.5 clk = ~clk;

  // ==========================================================
  // Reference queue, done counter and a ceiling against hangs.
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) q.push_back(sample.code);
    if (done === 1'b1) done_seen++;
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Offer one random word and hold it until the buffer takes it.
  task automatic offer();
    valid <= 1'b1;
    sample.code <= 12'($urandom);
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    @(posedge clk);
  endtask : offer

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Fill the buffer past full, then run frames of several lengths.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    valid = 1'b0;
    sample = '0;
    last = SARRO_SAMPLE_RST;
    void'($urandom(6822));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    offer();
    offer();
    valid <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, ready}, 32'h0);
    valid <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      if (i == 3 || i == 5) offer();
      // An empty buffer makes the frame repeat the previous word.
      code = (q.size() > 0) ? q.pop_front() : last;
      last = code;
      exp_b = '0;
      exp_o = '0;
      for (int k = 2; k <= nf[i]; k++) begin
        exp_o[k] = 1'b1;
        if (k >= 3 && k <= 14) exp_b[k] = code[14-k];
        if (k >= 15 && k <= 25) exp_b[k] = code[k-14];
      end
      if (nf[i] >= 14) done_exp++;
      host.frame(nf[i], bits, oes);
      repeat (8) @(posedge clk);
      chk(bits, exp_b);
      chk(oes, exp_o);
      chk({31'h0, oe}, 32'h0);
      chk(32'(done_seen), 32'(done_exp));
      $display("frame test %0d of %0d falls ended", i, nf[i]);
    end
    complete_run();
  end
endmodule : tb_top
